// ---- hw/asrsc_regs.vh ----
// Purpose: constants for the sync, reset and standby control block
// Assumes: master clock of 125 MHz, 8 ns period
// Notes: output-rate period is given in master clock cycles
`ifndef ASRSC_REGS_VH
`define ASRSC_REGS_VH
// output-rate period in master clock cycles
`define ASRSC_RATE_CYC 16'h0FA0
`define ASRSC_RATE_W 16
// periods of filter settling after a restart
`define ASRSC_SETTLE_PER 2'h3
// high pulse on an update over an unread word, in master clock periods
`define ASRSC_PULSE_TCLK 10'h1F4
`define ASRSC_PULSE_W 10
`define ASRSC_DATA_W 24
`endif

// ---- hw/asrsc_rate_div.v ----
// Purpose: output-rate divider, one-cycle enable per output period
// Assumes: clr holds the count at zero
// Notes: first tick comes one full period after clr drops
`include "asrsc_regs.vh"
module asrsc_rate_div (
  input wire mclk,
  input wire rst,
  input wire clr,
  output wire tick
);
  reg [`ASRSC_RATE_W-1:0] cnt_q;
  reg [`ASRSC_RATE_W-1:0] cnt_d;
  assign tick = ~clr && (cnt_q == `ASRSC_RATE_CYC - 16'h0001);
  always @* begin
    cnt_d = cnt_q + 16'h0001;
    if (clr || tick) begin
      cnt_d = 16'h0000;
    end
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- hw/asrsc_data_reg.v ----
// Purpose: output data register, keeps its word through standby
// Assumes: load is a one-cycle pulse, except that it is held high through a hard reset
// Notes: read data come from the register itself
`include "asrsc_regs.vh"
module asrsc_data_reg (
  input wire mclk,
  input wire rst,
  input wire load,
  input wire [`ASRSC_DATA_W-1:0] wdata,
  output reg [`ASRSC_DATA_W-1:0] rdata
);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 24'h00_0000;
    end else if (load) begin
      rdata <= wdata;
    end
  end
endmodule

// ---- hw/asrsc_ctrl.v ----
// Purpose: sync, hardware reset and standby control of a converter core
// Assumes: pins sampled on mclk; mclk keeps running in reset and standby
// Notes: filter result arrives on core_word with core_valid once per output period
`include "asrsc_regs.vh"
module asrsc_ctrl (
  input wire mclk,
  input wire rst,
  input wire reset_n,
  input wire sync_n,
  input wire standby_n,
  input wire filter_restart_bit,
  input wire core_valid,
  input wire [`ASRSC_DATA_W-1:0] core_word,
  input wire data_rd_done,
  input wire serial_req,
  output wire mclk_out,
  output wire filter_clear,
  output wire core_run,
  output wire serial_reset,
  output wire serial_grant,
  output wire rate_tick,
  output reg result_ready_n,
  output wire [`ASRSC_DATA_W-1:0] data_out
);
  localparam ST_RUN = 2'b00;
  localparam ST_SETTLE = 2'b01;
  localparam ST_HOLD = 2'b10;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [1:0] per_q;
  reg [1:0] per_d;
  reg [`ASRSC_PULSE_W-1:0] pulse_q;
  reg [`ASRSC_PULSE_W-1:0] pulse_d;
  reg rdy_n_d;
  reg load;
  reg hard_rst_q;
  wire hold;
  wire tick;

  assign mclk_out = mclk;
  // hard reset pin resets everything except the clock path
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hard_rst_q <= 1'b1;
    end else begin
      hard_rst_q <= ~reset_n;
    end
  end

  assign hold = ~sync_n | filter_restart_bit | ~standby_n | hard_rst_q;
  assign filter_clear = hold;
  assign core_run = ~hold;
  assign serial_reset = ~standby_n | hard_rst_q;
  assign serial_grant = serial_req & standby_n & ~hard_rst_q;
  assign rate_tick = tick;

  asrsc_rate_div u_div (
    .mclk(mclk),
    .rst(rst),
    .clr(hold),
    .tick(tick)
  );

  // hard reset returns the data register to its default word
  asrsc_data_reg u_data (
    .mclk(mclk),
    .rst(rst),
    .load(load | hard_rst_q),
    .wdata(hard_rst_q ? 24'h00_0000 : core_word),
    .rdata(data_out)
  );

  always @* begin
    st_d = st_q;
    per_d = per_q;
    pulse_d = pulse_q;
    rdy_n_d = result_ready_n;
    load = 1'b0;
    case (st_q)
      ST_HOLD: begin
        per_d = 2'h0;
        if (!hold) begin
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tick) begin
          per_d = per_q + 2'h1;
          if (per_q + 2'h1 == `ASRSC_SETTLE_PER) begin
            st_d = ST_RUN;
            load = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (core_valid) begin
          load = 1'b1;
        end
      end
      default: begin
        st_d = ST_HOLD;
      end
    endcase
    if (data_rd_done && serial_grant) begin
      rdy_n_d = 1'b1;
    end
    if (pulse_q != 10'h000) begin
      pulse_d = pulse_q - 10'h001;
      if (pulse_q == 10'h001) begin
        rdy_n_d = 1'b0;
      end
    end
    if (load) begin
      if (!result_ready_n) begin
        rdy_n_d = 1'b1;
        pulse_d = `ASRSC_PULSE_TCLK;
      end else begin
        rdy_n_d = 1'b0;
      end
    end
    // a low ready across a sync stays low
    if (hold) begin
      st_d = ST_HOLD;
      load = 1'b0;
      pulse_d = 10'h000;
      if (!standby_n || hard_rst_q) begin
        rdy_n_d = 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_HOLD;
      per_q <= 2'h0;
      pulse_q <= 10'h000;
      result_ready_n <= 1'b1;
    end else begin
      st_q <= st_d;
      per_q <= per_d;
      pulse_q <= pulse_d;
      result_ready_n <= rdy_n_d;
    end
  end
endmodule

// ---- sim/asrsc_core.sv ----
// Purpose: filter core stand-in
// Assumes: word set by the bench
// Notes: off-tick word is inverted
module asrsc_core (
  input wire rate_tick,
  input wire core_run,
  input wire [23:0] word,
  output wire core_valid,
  output wire [23:0] core_word
);
  assign core_valid = rate_tick && core_run;
  assign core_word = core_valid ? word : ~word;
endmodule

// ---- sim/asrsc_chk_sva.sv ----
// Purpose: port checks
// Assumes: one clock
// Notes: cnt_q counts run cycles
`include "asrsc_regs.vh"
module asrsc_chk (
  input wire mclk,
  input wire rst,
  input wire reset_n,
  input wire sync_n,
  input wire standby_n,
  input wire filter_restart_bit,
  input wire data_rd_done,
  input wire mclk_out,
  input wire filter_clear,
  input wire serial_reset,
  input wire serial_grant,
  input wire result_ready_n,
  input wire [23:0] data_out
);
  localparam int ST = `ASRSC_RATE_CYC * `ASRSC_SETTLE_PER;
  int cnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always @(posedge mclk) cnt_q <= filter_clear ? 0 : cnt_q + 1;
  property p_hold; (!sync_n || filter_restart_bit) [*2] |-> filter_clear; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_free; (sync_n && !filter_restart_bit && standby_n && reset_n) [*3] |-> !filter_clear;
  endproperty
  a_free: assert property (p_free) else $error("free");
  property p_hrst; !reset_n [*3] |-> result_ready_n && !serial_grant; endproperty
  a_hrst: assert property (p_hrst) else $error("reset");
  property p_sby; !standby_n [*3] |-> result_ready_n && serial_reset; endproperty
  a_sby: assert property (p_sby) else $error("standby");
  property p_clk; @(negedge mclk) mclk_out; endproperty
  a_clk: assert property (p_clk) else $error("clock");
  property p_keep; (!sync_n && reset_n) [*3] |-> $stable(data_out); endproperty
  a_keep: assert property (p_keep) else $error("load");
  property p_read; data_rd_done |=> result_ready_n; endproperty
  a_read: assert property (p_read) else $error("read");
  property p_set; $fell(result_ready_n) |-> cnt_q + 2 >= ST; endproperty
  a_set: assert property (p_set) else $error("early");
endmodule
bind asrsc_ctrl asrsc_chk u_chk (
  .mclk(mclk),
  .rst(rst),
  .reset_n(reset_n),
  .sync_n(sync_n),
  .standby_n(standby_n),
  .filter_restart_bit(filter_restart_bit),
  .data_rd_done(data_rd_done),
  .mclk_out(mclk_out),
  .filter_clear(filter_clear),
  .serial_reset(serial_reset),
  .serial_grant(serial_grant),
  .result_ready_n(result_ready_n),
  .data_out(data_out)
);

// ---- sim/tb_top.sv ----
// Purpose: bench of asrsc_ctrl
// Assumes: 8 ns mclk
// Notes: fixed seed
`include "asrsc_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = `ASRSC_RATE_CYC * `ASRSC_SETTLE_PER;
  logic mclk = 0, rst = 1, reset_n = 1, sync_n = 1, standby_n = 1, filter_restart_bit = 0;
  logic data_rd_done = 0, serial_req = 0, core_valid, rate_tick, core_run, mclk_out;
  logic filter_clear, serial_reset, serial_grant, result_ready_n;
  logic [23:0] word = 0, core_word, data_out, h;
  int miscompares = 0, checked = 0, n;
  asrsc_core u_asrsc_core (.*);
  asrsc_ctrl u_asrsc_ctrl (.*);
  task automatic summarize;
    $display("errors %0d checks %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (result_ready_n !== v && n < 20000) begin @(posedge mclk); n++; end
  endtask
  task automatic settle;
    wt(0);
    `CHK({n > ST - 3 && n < ST + 5, data_out}, {1'h1, word})
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(32'ha992_a2de));
    word <= 24'($urandom);
    repeat (10) @(posedge mclk);
    rst <= 0;
    settle();
    sync_n <= 0;
    word <= 24'($urandom);
    repeat ($urandom_range(9, 3)) @(posedge mclk);
    sync_n <= 1;
    wt(1);
    `CHK(n > ST - 3 && n < ST + 5, 1'h1)
    wt(0);
    `CHK({n, data_out}, {32'h0000_01f4, word})
    data_rd_done <= 1;
    serial_req <= 1;
    @(posedge mclk) data_rd_done <= 0;
    @(posedge mclk) `CHK(result_ready_n, 1'h1)
    for (int k = 0; k < 3; k++) begin
      h = k == 2 ? 24'h00_0000 : word;
      {reset_n, standby_n, filter_restart_bit} <= {k != 2, k != 1, k == 0};
      serial_req <= 1'($urandom);
      word <= 24'($urandom);
      repeat (30) @(posedge mclk);
      `CHK({result_ready_n, serial_grant, data_out}, {1'h1, serial_req && k == 0, h})
      `CHK({core_run, rate_tick, serial_reset}, {2'h0, k != 0})
      {reset_n, standby_n, filter_restart_bit} <= 3'h6;
      settle();
    end
    summarize();
  end
endmodule
